// ### pcie_ext_capability_regs.sv
// extended capability register bank: header log, serial number and vc capability words
//
// Functional notes
// - offset 0x11C reads sticky first header doubleword of first uncorrectable error
// - offset 0x120 reads sticky second header doubleword
// - offset 0x124 reads sticky third header doubleword
// - offset 0x128 reads sticky fourth header doubleword
// - serial capability header reads identifier 0x3 and version 0x1
// - serial low word at 0x184 is sticky, lockable, resets zero
// - serial high word at 0x188 is sticky, lockable, resets zero
// - vc capability header reads identifier 0x2 and version 0x1
// - vc next pointer resets to zero and is write-lockable
// - extended vc count reads zero
// - low priority extended vc count reads zero
// - time reference field reads zero, no time-based arbitration
// - upstream port reports entry size code 0x2, four-bit entries
// - downstream ports report entry size code zero
// - entry size codes 0..3 mean 1, 2, 4, 8 bit entries
`default_nettype none
module pcie_ext_capability_regs (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sticky_rst_n,
    input wire logic upstream_port,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_valid,
    input wire ext_cap_pkg::header_log_type capture_header,
    input wire logic capture_rearm,
    output logic [63:0] serial_number,
    output logic [3:0] entry_width_bits
);
    // ----------------------------------------------------------------
    // bus front end and sticky header store
    // ----------------------------------------------------------------
    ext_cap_pkg::bus_request_type request;
    ext_cap_pkg::header_log_type header_log;

    apb_access u_apb_access (
        .clock(clock),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .request(request)
    );

    header_log_store u_header_log_store (
        .clock(clock),
        .sticky_rst_n(sticky_rst_n),
        .capture_valid(capture_valid),
        .capture_header(capture_header),
        .rearm(capture_rearm),
        .header_log(header_log)
    );

    // ----------------------------------------------------------------
    // writable state
    // ----------------------------------------------------------------
    logic [31:0] serial_low;
    logic [31:0] serial_high;
    logic [11:0] serial_next_pointer;
    logic [11:0] vc_next_pointer;
    logic write_lock;
    logic unlocked_write;
    logic bus_write;
    logic bus_read_setup;

    assign bus_write = request.valid && request.write;
    // lockable fields take writes only while the lock is open
    assign unlocked_write = bus_write && !write_lock;
    assign bus_read_setup = psel && !penable && !pwrite;

    // the lock lives in the ordinary domain so a normal reset reopens it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            write_lock <= 1'b0;
        end else if (bus_write && request.addr == ext_cap_pkg::write_lock_offset) begin
            write_lock <= request.wdata[0];
        end
    end

    // serial words survive ordinary resets
    always_ff @(posedge clock or negedge sticky_rst_n) begin
        if (!sticky_rst_n) begin
            serial_low <= ext_cap_pkg::word_reset;
            serial_high <= ext_cap_pkg::word_reset;
        end else if (unlocked_write) begin
            if (request.addr == ext_cap_pkg::serial_number_low_word_offset) begin
                serial_low <= request.wdata;
            end
            if (request.addr == ext_cap_pkg::serial_number_high_word_offset) begin
                serial_high <= request.wdata;
            end
        end
    end

    // only bits 31:20 of the headers are writable; identifier and version are constants
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            serial_next_pointer <= ext_cap_pkg::next_pointer_reset;
            vc_next_pointer <= ext_cap_pkg::next_pointer_reset;
        end else if (unlocked_write) begin
            if (request.addr == ext_cap_pkg::serial_number_cap_header_offset) begin
                serial_next_pointer <= request.wdata[31:20];
            end
            if (request.addr == ext_cap_pkg::virtual_channel_cap_header_offset) begin
                vc_next_pointer <= request.wdata[31:20];
            end
        end
    end

    // ----------------------------------------------------------------
    // read decode
    // ----------------------------------------------------------------
    ext_cap_pkg::cap_header_type serial_header;
    ext_cap_pkg::cap_header_type vc_header;
    ext_cap_pkg::port_vc_cap_one_type vc_cap_one;
    ext_cap_pkg::entry_size_type entry_size;
    logic [31:0] next_prdata;
    logic next_hit;

    always_comb begin
        entry_size = upstream_port ? ext_cap_pkg::entry_size_type'(ext_cap_pkg::entry_size_upstream)
            : ext_cap_pkg::entry_size_type'(ext_cap_pkg::entry_size_downstream);
        serial_header.capability_identifier = ext_cap_pkg::serial_cap_identifier;
        serial_header.capability_version = ext_cap_pkg::cap_version_one;
        serial_header.next_capability_pointer = serial_next_pointer;
        vc_header.capability_identifier = ext_cap_pkg::vc_cap_identifier;
        vc_header.capability_version = ext_cap_pkg::cap_version_one;
        vc_header.next_capability_pointer = vc_next_pointer;
        vc_cap_one = '0;
        vc_cap_one.extended_vc_count = ext_cap_pkg::extended_vc_count_value;
        vc_cap_one.low_priority_vc_count = ext_cap_pkg::low_priority_vc_count_value;
        vc_cap_one.wrr_time_reference = ext_cap_pkg::wrr_time_reference_value;
        vc_cap_one.port_arb_table_entry_size = entry_size;
    end

    always_comb begin
        next_hit = 1'b1;
        next_prdata = ext_cap_pkg::unmapped_read;
        case (paddr & 12'hffc)
            ext_cap_pkg::error_header_log_word0_offset: next_prdata = header_log.word0;
            ext_cap_pkg::error_header_log_word1_offset: next_prdata = header_log.word1;
            ext_cap_pkg::error_header_log_word2_offset: next_prdata = header_log.word2;
            ext_cap_pkg::error_header_log_word3_offset: next_prdata = header_log.word3;
            ext_cap_pkg::serial_number_cap_header_offset: next_prdata = serial_header;
            ext_cap_pkg::serial_number_low_word_offset: next_prdata = serial_low;
            ext_cap_pkg::serial_number_high_word_offset: next_prdata = serial_high;
            ext_cap_pkg::virtual_channel_cap_header_offset: next_prdata = vc_header;
            ext_cap_pkg::port_vc_capability_one_offset: next_prdata = vc_cap_one;
            ext_cap_pkg::write_lock_offset: next_prdata = {31'h0000_0000, write_lock};
            default: next_hit = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // registered bus answer: data latched in setup, ready in access
    // ----------------------------------------------------------------
    logic hit;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= ext_cap_pkg::unmapped_read;
        end else if (bus_read_setup) begin
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hit <= 1'b0;
        end else if (psel && !penable) begin
            hit <= next_hit;
        end
    end

    // ready rises with the first access cycle and stands for one cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !next_hit;
        end
    end

    // ----------------------------------------------------------------
    // user-side outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge sticky_rst_n) begin
        if (!sticky_rst_n) begin
            serial_number <= '0;
            entry_width_bits <= 4'h0;
        end else begin
            serial_number <= {serial_high, serial_low};
            entry_width_bits <= ext_cap_pkg::entry_bits(entry_size);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_serial_locked;
        @(posedge clock) disable iff (!sticky_rst_n || !rst_n)
        (bus_write && write_lock) |=> $stable(serial_low) && $stable(serial_high);
    endproperty
    a_serial_locked: assert property (p_serial_locked)
        else $error("serial word changed while locked");

    property p_serial_low_write;
        @(posedge clock) disable iff (!sticky_rst_n || !rst_n)
        (unlocked_write && request.addr == ext_cap_pkg::serial_number_low_word_offset)
            |=> serial_low == $past(request.wdata);
    endproperty
    a_serial_low_write: assert property (p_serial_low_write)
        else $error("serial low word missed a write");

    property p_serial_high_write;
        @(posedge clock) disable iff (!sticky_rst_n || !rst_n)
        (unlocked_write && request.addr == ext_cap_pkg::serial_number_high_word_offset)
            |=> serial_high == $past(request.wdata);
    endproperty
    a_serial_high_write: assert property (p_serial_high_write)
        else $error("serial high word missed a write");

    sequence s_setup_at(logic [11:0] where);
        psel && !penable && !pwrite && (paddr & 12'hffc) == where;
    endsequence

    property p_serial_header_read;
        @(posedge clock) disable iff (!rst_n)
        s_setup_at(ext_cap_pkg::serial_number_cap_header_offset)
            |=> prdata[19:0] == 20'h10003 && pready;
    endproperty
    a_serial_header_read: assert property (p_serial_header_read)
        else $error("serial header identifier or version wrong");

    property p_vc_header_read;
        @(posedge clock) disable iff (!rst_n)
        s_setup_at(ext_cap_pkg::virtual_channel_cap_header_offset)
            |=> prdata[19:0] == 20'h10002 && prdata[31:20] == $past(vc_next_pointer);
    endproperty
    a_vc_header_read: assert property (p_vc_header_read)
        else $error("vc header read wrong");

    property p_vc_cap_one_read;
        @(posedge clock) disable iff (!rst_n)
        s_setup_at(ext_cap_pkg::port_vc_capability_one_offset)
            |=> prdata == ($past(upstream_port) ? 32'h0000_0800 : 32'h0000_0000);
    endproperty
    a_vc_cap_one_read: assert property (p_vc_cap_one_read)
        else $error("port vc capability one read wrong");

    property p_header_log_read;
        @(posedge clock) disable iff (!rst_n || !sticky_rst_n)
        s_setup_at(ext_cap_pkg::error_header_log_word0_offset)
            |=> prdata == $past(header_log.word0);
    endproperty
    a_header_log_read: assert property (p_header_log_read)
        else $error("header log word0 read wrong");

    property p_header_log_word1_read;
        @(posedge clock) disable iff (!rst_n || !sticky_rst_n)
        s_setup_at(ext_cap_pkg::error_header_log_word1_offset)
            |=> prdata == $past(header_log.word1);
    endproperty
    a_header_log_word1_read: assert property (p_header_log_word1_read)
        else $error("header log word1 read wrong");

    property p_header_log_word2_read;
        @(posedge clock) disable iff (!rst_n || !sticky_rst_n)
        s_setup_at(ext_cap_pkg::error_header_log_word2_offset)
            |=> prdata == $past(header_log.word2);
    endproperty
    a_header_log_word2_read: assert property (p_header_log_word2_read)
        else $error("header log word2 read wrong");

    property p_header_log_word3_read;
        @(posedge clock) disable iff (!rst_n || !sticky_rst_n)
        s_setup_at(ext_cap_pkg::error_header_log_word3_offset)
            |=> prdata == $past(header_log.word3);
    endproperty
    a_header_log_word3_read: assert property (p_header_log_word3_read)
        else $error("header log word3 read wrong");

    property p_header_log_ro;
        @(posedge clock) disable iff (!rst_n || !sticky_rst_n)
        (bus_write && !capture_valid) |=> $stable(header_log);
    endproperty
    a_header_log_ro: assert property (p_header_log_ro)
        else $error("header log changed by a write");

    property p_vc_pointer_locked;
        @(posedge clock) disable iff (!rst_n)
        (bus_write && write_lock) |=> $stable(vc_next_pointer);
    endproperty
    a_vc_pointer_locked: assert property (p_vc_pointer_locked)
        else $error("vc next pointer changed while locked");

    property p_ready_one_cycle;
        @(posedge clock) disable iff (!rst_n)
        pready |=> !pready;
    endproperty
    a_ready_one_cycle: assert property (p_ready_one_cycle)
        else $error("pready stood longer than one cycle");

    property p_unmapped_read;
        @(posedge clock) disable iff (!rst_n)
        s_setup_at(ext_cap_pkg::port_vc_capability_one_offset + 12'h004)
            |=> pready && pslverr && prdata == ext_cap_pkg::unmapped_read;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not refused");

    property p_lock_write;
        @(posedge clock) disable iff (!rst_n)
        (bus_write && request.addr == ext_cap_pkg::write_lock_offset)
            |=> write_lock == $past(request.wdata[0]);
    endproperty
    a_lock_write: assert property (p_lock_write)
        else $error("write lock missed a write");

    property p_serial_number_out;
        @(posedge clock) disable iff (!sticky_rst_n)
        1'b1 |=> serial_number == $past({serial_high, serial_low});
    endproperty
    a_serial_number_out: assert property (p_serial_number_out)
        else $error("serial number output wrong");

    property p_entry_width;
        @(posedge clock) disable iff (!sticky_rst_n)
        1'b1 |=> entry_width_bits == ($past(upstream_port) ? 4'h4 : 4'h1);
    endproperty
    a_entry_width: assert property (p_entry_width)
        else $error("entry width output wrong");

    logic unused_hit;
    assign unused_hit = hit;
endmodule
`default_nettype wire

// ### ext_cap_pkg.sv
// package: register map, field layout and shared types of the extended capability bank
`default_nettype none
package ext_cap_pkg;
    localparam int unsigned addr_width = 12;
    localparam int unsigned data_width = 32;
    // register byte offsets
    localparam logic [11:0] error_header_log_word0_offset = 12'h11c;
    localparam logic [11:0] error_header_log_word1_offset = 12'h120;
    localparam logic [11:0] error_header_log_word2_offset = 12'h124;
    localparam logic [11:0] error_header_log_word3_offset = 12'h128;
    localparam logic [11:0] serial_number_cap_header_offset = 12'h180;
    localparam logic [11:0] serial_number_low_word_offset = 12'h184;
    localparam logic [11:0] serial_number_high_word_offset = 12'h188;
    localparam logic [11:0] virtual_channel_cap_header_offset = 12'h200;
    localparam logic [11:0] port_vc_capability_one_offset = 12'h204;
    localparam logic [11:0] write_lock_offset = 12'h300;
    // capability header fields
    localparam logic [15:0] serial_cap_identifier = 16'h0003;
    localparam logic [15:0] vc_cap_identifier = 16'h0002;
    localparam logic [3:0] cap_version_one = 4'h1;
    localparam logic [11:0] next_pointer_reset = 12'h000;
    // port vc capability 1 fields
    localparam logic [2:0] extended_vc_count_value = 3'h0;
    localparam logic [2:0] low_priority_vc_count_value = 3'h0;
    localparam logic [1:0] wrr_time_reference_value = 2'h0;
    localparam logic [1:0] entry_size_upstream = 2'h2;
    localparam logic [1:0] entry_size_downstream = 2'h0;
    localparam logic [31:0] word_reset = 32'h0000_0000;
    localparam logic [31:0] unmapped_read = 32'h0000_0000;

    // entry size code: 0 -> 1 bit, 1 -> 2 bits, 2 -> 4 bits, 3 -> 8 bits
    typedef enum logic [1:0] {
        entry_one_bit = 2'h0,
        entry_two_bit = 2'h1,
        entry_four_bit = 2'h2,
        entry_eight_bit = 2'h3
    } entry_size_type;

    typedef struct packed {
        logic [11:0] next_capability_pointer;
        logic [3:0] capability_version;
        logic [15:0] capability_identifier;
    } cap_header_type;

    typedef struct packed {
        logic [19:0] reserved_high;
        entry_size_type port_arb_table_entry_size;
        logic [1:0] wrr_time_reference;
        logic reserved_7;
        logic [2:0] low_priority_vc_count;
        logic reserved_3;
        logic [2:0] extended_vc_count;
    } port_vc_cap_one_type;

    typedef struct packed {
        logic [31:0] word3;
        logic [31:0] word2;
        logic [31:0] word1;
        logic [31:0] word0;
    } header_log_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } bus_request_type;

    // width of the entry named by a size code, in bits
    function automatic logic [3:0] entry_bits(input entry_size_type code);
        case (code)
            entry_one_bit: entry_bits = 4'h1;
            entry_two_bit: entry_bits = 4'h2;
            entry_four_bit: entry_bits = 4'h4;
            default: entry_bits = 4'h8;
        endcase
    endfunction
endpackage
`default_nettype wire

// ### apb_access.sv
// apb slave front end: one wait-free access phase, turns a transfer into a request struct
`default_nettype none
module apb_access (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output ext_cap_pkg::bus_request_type request
);
    // the request is combinational so the bank can answer in the same access cycle
    always_comb begin
        request.valid = psel && penable;
        request.write = pwrite;
        request.addr = {paddr[11:2], 2'b00};
        request.wdata = pwdata;
    end

    logic unused_inputs;
    always_comb begin
        unused_inputs = clock ^ rst_n ^ paddr[1] ^ paddr[0];
    end
endmodule
`default_nettype wire

// ### header_log_store.sv
// sticky four-word store for the header of the first reported uncorrectable error
`default_nettype none
module header_log_store (
    input wire logic clock,
    input wire logic sticky_rst_n,
    input wire logic capture_valid,
    input wire ext_cap_pkg::header_log_type capture_header,
    input wire logic rearm,
    output ext_cap_pkg::header_log_type header_log
);
    logic held;

    // only the first error is kept; a later capture is dropped until software rearms
    always_ff @(posedge clock or negedge sticky_rst_n) begin
        if (!sticky_rst_n) begin
            header_log <= '0;
        end else if (capture_valid && !held) begin
            header_log <= capture_header;
        end
    end

    // a capture in the rearm cycle wins and leaves the store held
    always_ff @(posedge clock or negedge sticky_rst_n) begin
        if (!sticky_rst_n) begin
            held <= 1'b0;
        end else if (capture_valid) begin
            held <= 1'b1;
        end else if (rearm) begin
            held <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### pcie_ext_capability_regs_tb_top.sv
// self-checking testbench for the extended capability register bank
`default_nettype none
module pcie_ext_capability_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic sticky_rst_n = 1'b0;
    logic upstream_port = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic capture_valid = 1'b0;
    ext_cap_pkg::header_log_type capture_header = '0;
    logic capture_rearm = 1'b0;
    logic [63:0] serial_number;
    logic [3:0] entry_width_bits;
    int err_count = 0;
    int tests_run = 0;

    pcie_ext_capability_regs pcie_ext_capability_regs_i (
        .clock(clock), .rst_n(rst_n), .sticky_rst_n(sticky_rst_n),
        .upstream_port(upstream_port), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_valid(capture_valid),
        .capture_header(capture_header), .capture_rearm(capture_rearm),
        .serial_number(serial_number), .entry_width_bits(entry_width_bits)
    );

    initial begin
        forever #12.5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // entered just after a rising edge; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_count++;
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so a following call never reassigns psel in this time step
        @(posedge clock);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0000_0000, rd, er);
        check(what, {32'h0, rd}, {32'h0, exp});
        check({what, " slverr"}, {63'h0, er}, 64'h0);
    endtask

    task automatic pulse_rst(input logic sticky);
        if (sticky) sticky_rst_n <= 1'b0;
        else rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        sticky_rst_n <= 1'b1;
        rst_n <= 1'b1;
        @(posedge clock);
    endtask

    task automatic capture(input logic [127:0] h, input logic rearm);
        capture_header <= h;
        capture_valid <= 1'b1;
        capture_rearm <= rearm;
        @(posedge clock);
        capture_valid <= 1'b0;
        capture_rearm <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd_log(input logic [127:0] h);
        for (int i = 0; i < 4; i++) begin
            rd_chk(12'h11c + 12'(4 * i), h[32 * i +: 32], "header log");
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        rd_log(128'h0);
        rd_chk(12'h180, 32'h0001_0003, "serial cap header");
        rd_chk(12'h184, 32'h0000_0000, "serial low");
        rd_chk(12'h188, 32'h0000_0000, "serial high");
        rd_chk(12'h200, 32'h0001_0002, "vc cap header");
        rd_chk(12'h204, 32'h0000_0800, "port vc cap up");
        check("width up", {60'h0, entry_width_bits}, 64'h4);
    endtask

    // writes all ones into read-only words and ones into header bits 19:0; none may stick
    task automatic t_readonly();
        for (int i = 0; i < 4; i++) wr(12'h11c + 12'(4 * i), 32'hffff_ffff);
        wr(12'h204, 32'hffff_ffff);
        wr(12'h180, 32'h000f_ffff);
        wr(12'h200, 32'h000f_ffff);
        rd_log(128'h0);
        rd_chk(12'h204, 32'h0000_0800, "port vc cap ro");
        rd_chk(12'h180, 32'h0001_0003, "serial hdr ro");
        rd_chk(12'h200, 32'h0001_0002, "vc hdr ro");
    endtask

    // only the first error is kept until rearmed, and it survives ordinary reset
    task automatic t_capture();
        logic [127:0] h1;
        logic [127:0] h2;
        h1 = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
        h2 = 128'ha5a5_5a5a_0f0f_f0f0_3c3c_c3c3_1111_eeee;
        capture(h1, 1'b0);
        rd_log(h1);
        capture(h2, 1'b0);
        rd_log(h1);
        pulse_rst(1'b0);
        rd_log(h1);
        capture(h1, 1'b1);
        rd_log(h1);
        capture(h2, 1'b0);
        rd_log(h1);
        capture_rearm <= 1'b1;
        @(posedge clock);
        capture(h2, 1'b0);
        rd_log(h2);
    endtask

    task automatic t_serial();
        wr(12'h184, 32'h1234_5678);
        wr(12'h188, 32'h9abc_def0);
        rd_chk(12'h184, 32'h1234_5678, "serial low wr");
        rd_chk(12'h188, 32'h9abc_def0, "serial high wr");
        check("serial out", serial_number, 64'h9abc_def0_1234_5678);
        wr(12'h180, 32'h5a50_0000);
        rd_chk(12'h180, 32'h5a51_0003, "serial next ptr wr");
        wr(12'h200, 32'h1230_0000);
        rd_chk(12'h200, 32'h1231_0002, "vc next ptr wr");
        wr(12'h300, 32'h0000_0001);
        wr(12'h184, 32'hdead_0001);
        wr(12'h188, 32'hdead_0002);
        wr(12'h200, 32'h7770_0000);
        rd_chk(12'h184, 32'h1234_5678, "serial low locked");
        rd_chk(12'h188, 32'h9abc_def0, "serial high locked");
        rd_chk(12'h200, 32'h1231_0002, "vc next ptr locked");
        pulse_rst(1'b0);
        rd_chk(12'h200, 32'h0001_0002, "vc next ptr reset");
        rd_chk(12'h184, 32'h1234_5678, "serial low sticky");
        rd_chk(12'h188, 32'h9abc_def0, "serial high sticky");
        pulse_rst(1'b1);
        repeat (2) @(posedge clock);
        rd_chk(12'h184, 32'h0000_0000, "serial low cold");
        check("serial out cold", serial_number, 64'h0);
        rd_log(128'h0);
    endtask

    task automatic t_downstream();
        upstream_port <= 1'b0;
        repeat (2) @(posedge clock);
        rd_chk(12'h204, 32'h0000_0000, "port vc cap down");
        check("width down", {60'h0, entry_width_bits}, 64'h1);
        upstream_port <= 1'b1;
        repeat (2) @(posedge clock);
        check("width up again", {60'h0, entry_width_bits}, 64'h4);
    endtask

    task automatic t_unmapped();
        logic [31:0] rd;
        logic er;
        apb(1'b1, 12'h208, 32'hffff_ffff, rd, er);
        apb(1'b0, 12'h208, 32'h0000_0000, rd, er);
        check("unmapped data", {32'h0, rd}, 64'h0);
        check("unmapped slverr", {63'h0, er}, 64'h1);
    endtask

    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        sticky_rst_n <= 1'b1;
        @(posedge clock);
        t_reset_values();
        t_readonly();
        t_capture();
        t_serial();
        t_downstream();
        t_unmapped();
        end_sim();
    end
endmodule
`default_nettype wire
